// File: core/ptz_pkg.sv
package ptz_pkg;
  // register indexes; byte address is four times the index
  localparam logic [6:0] IDX_SRC_SEL   = 7'h24;
  localparam logic [6:0] IDX_ACTION    = 7'h28;
  localparam logic [6:0] IDX_IRQ_EN    = 7'h2a;
  localparam logic [6:0] IDX_STATUS    = 7'h2c;
  localparam logic [6:0] IDX_CLEAR     = 7'h2e;
  localparam logic [6:0] IDX_FORCE     = 7'h30;
  localparam logic [6:0] IDX_EVT_STAT  = 7'h38;
  localparam logic [6:0] IDX_EVT_MASK  = 7'h3a;

  // field positions
  localparam int SEL_OST_LSB  = 8;
  localparam int SEL_CBC_LSB  = 0;
  localparam int ACT_A_LSB    = 0;
  localparam int ACT_B_LSB    = 2;
  localparam int BIT_OST      = 2;
  localparam int BIT_CBC      = 1;
  localparam int BIT_INT      = 0;
  localparam int EVT_IRQ      = 0;
  localparam int EVT_CBC      = 1;
  localparam int EVT_OST      = 2;

  // values after reset; TB_ZERO is the time-base zero point
  localparam logic [15:0] RST_SRC_SEL = 16'h0000;
  localparam logic [3:0]  RST_ACTION  = 4'h0;
  localparam logic [1:0]  RST_IRQ_EN  = 2'h0;
  localparam logic [2:0]  RST_EVT     = 3'h0;
  localparam logic [15:0] TB_ZERO     = 16'h0000;

  // trip output actions
  localparam logic [1:0] ACT_HIZ  = 2'h0;
  localparam logic [1:0] ACT_HIGH = 2'h1;
  localparam logic [1:0] ACT_LOW  = 2'h2;
  localparam logic [1:0] ACT_NONE = 2'h3;

  typedef enum logic [0:0] {
    PTZ_BUS_IDLE = 1'b0,
    PTZ_BUS_ACK  = 1'b1
  } ptz_bus_t;
endpackage

// File: core/ptz_sync.sv
`timescale 1ns/100ps
`default_nettype none
// two-stage synchroniser; stage one feeds only stage two
module ptz_sync #(
  parameter int       WIDTH    = 8,
  parameter bit [0:0] RST_LVL  = 1'b1
) (
  input  wire logic             sys_clk,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1_reg;

  // resets to the idle level so no false trip appears after reset
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      stage1_reg <= {WIDTH{RST_LVL}};
      syncOut    <= {WIDTH{RST_LVL}};
    end else begin
      stage1_reg <= asyncIn;
      syncOut    <= stage1_reg;
    end
  end
endmodule // ptz_sync
`default_nettype wire

// File: core/ptz_trip_zone.sv
// Design decision made here: register access over Avalon-MM.
`timescale 1ns/100ps
`default_nettype none
module ptz_trip_zone
  import ptz_pkg::*;
#(
  parameter int NUM_FAULT = 8
) (
  input  wire logic                 sys_clk,
  input  wire logic                 srst,
  input  wire logic [8:0]           avsAddress,
  input  wire logic                 avsRead,
  input  wire logic                 avsWrite,
  input  wire logic [31:0]          avsWritedata,
  input  wire logic [3:0]           avsByteenable,
  output logic      [31:0]          avsReaddata,
  output logic                      avsWaitrequest,
  input  wire logic [NUM_FAULT-1:0] faultInN,
  input  wire logic [15:0]          timebaseCount,
  input  wire logic                 pwmInFirst,
  input  wire logic                 pwmInSecond,
  output logic                      pwmOutFirst,
  output logic                      pwmOutFirstOe,
  output logic                      pwmOutSecond,
  output logic                      pwmOutSecondOe,
  output logic                      faultIrqLine,
  output logic                      irq
);

  ////////////////////////////////////////////////////////////////////////////
  // fault pin synchronisation
  logic [NUM_FAULT-1:0] faultSyncN;

  ptz_sync #(
    .WIDTH   (NUM_FAULT),
    .RST_LVL (1'b1)
  ) u_fault_sync (
    .sys_clk (sys_clk),
    .srst    (srst),
    .asyncIn (faultInN),
    .syncOut (faultSyncN)
  );

  ////////////////////////////////////////////////////////////////////////////
  // avalon slave: waitrequest drops one cycle after a request is seen
  ptz_bus_t         busState_reg;
  logic [6:0]       regIdx;
  logic             wrDo;
  logic [15:0]      wrMask;
  logic [15:0]      wrData;
  logic [15:0]      rdMux;

  assign regIdx = avsAddress[8:2];
  assign wrDo   = avsWrite & (busState_reg == PTZ_BUS_ACK);
  assign wrMask = {{8{avsByteenable[1]}}, {8{avsByteenable[0]}}};
  assign wrData = avsWritedata[15:0] & wrMask;

  // bus handshake state, waitrequest out of a flop
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      busState_reg   <= PTZ_BUS_IDLE;
      avsWaitrequest <= 1'b1;
    end else begin
      case (busState_reg)
        PTZ_BUS_IDLE: begin
          if (avsRead | avsWrite) begin
            busState_reg   <= PTZ_BUS_ACK;
            avsWaitrequest <= 1'b0;
          end
        end
        PTZ_BUS_ACK: begin
          busState_reg   <= PTZ_BUS_IDLE;
          avsWaitrequest <= 1'b1;
        end
        default: begin
          busState_reg   <= PTZ_BUS_IDLE;
          avsWaitrequest <= 1'b1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software registers
  logic [15:0] srcSel_reg;
  logic [3:0]  action_reg;
  logic [1:0]  irqEn_reg;
  logic [2:0]  evtMask_reg;

  // plain read/write control registers, byte lanes honoured
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      srcSel_reg  <= RST_SRC_SEL;
      action_reg  <= RST_ACTION;
      irqEn_reg   <= RST_IRQ_EN;
      evtMask_reg <= RST_EVT;
    end else if (wrDo) begin
      if (regIdx == IDX_SRC_SEL)
        srcSel_reg <= (srcSel_reg & ~wrMask) | wrData;
      if (regIdx == IDX_ACTION && avsByteenable[0])
        action_reg <= wrData[3:0];
      if (regIdx == IDX_IRQ_EN && avsByteenable[0])
        irqEn_reg <= wrData[BIT_OST:BIT_CBC];
      if (regIdx == IDX_EVT_MASK && avsByteenable[0])
        evtMask_reg <= wrData[2:0];
    end
  end

  // write-one strobes; never stored, so the clear and force registers read zero
  logic clrOst;
  logic clrCbc;
  logic clrInt;
  logic frcOst;
  logic frcCbc;
  logic evtW1c;

  assign clrOst = wrDo & (regIdx == IDX_CLEAR) & wrData[BIT_OST];
  assign clrCbc = wrDo & (regIdx == IDX_CLEAR) & wrData[BIT_CBC];
  assign clrInt = wrDo & (regIdx == IDX_CLEAR) & wrData[BIT_INT];
  assign frcOst = wrDo & (regIdx == IDX_FORCE) & wrData[BIT_OST];
  assign frcCbc = wrDo & (regIdx == IDX_FORCE) & wrData[BIT_CBC];
  assign evtW1c = wrDo & (regIdx == IDX_EVT_STAT);

  ////////////////////////////////////////////////////////////////////////////
  // trip detection: a selected input held low is a live trip
  logic [NUM_FAULT-1:0] faultLow;
  logic                 ostEvent;
  logic                 cbcEvent;
  logic                 cbcPinLive;

  assign faultLow   = ~faultSyncN;
  assign ostEvent   = (|(faultLow & srcSel_reg[SEL_OST_LSB +: NUM_FAULT]))
                      | frcOst;
  assign cbcPinLive = |(faultLow
                        & srcSel_reg[SEL_CBC_LSB +: NUM_FAULT]);
  assign cbcEvent   = cbcPinLive | frcCbc;

  logic ostFlag_reg;
  logic cbcFlag_reg;
  logic cbcOverride_reg;
  logic intFlag_reg;
  logic intFlag_next;
  logic tbZero;

  assign tbZero = (timebaseCount == TB_ZERO);

  // sticky trip flags; a trip in the clear cycle wins over the clear
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ostFlag_reg <= 1'b0;
      cbcFlag_reg <= 1'b0;
    end else begin
      if (ostEvent)
        ostFlag_reg <= 1'b1;
      else if (clrOst)
        ostFlag_reg <= 1'b0;
      if (cbcEvent)
        cbcFlag_reg <= 1'b1;
      else if (clrCbc)
        cbcFlag_reg <= 1'b0;
    end
  end

  // per-cycle override ends only at counter zero with the fault gone;
  // a forced trip therefore holds until the next zero point
  always_ff @(posedge sys_clk) begin
    if (srst)
      cbcOverride_reg <= 1'b0;
    else if (cbcEvent)
      cbcOverride_reg <= 1'b1;
    else if (tbZero)
      cbcOverride_reg <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // trip interrupt: pulse only while the latched interrupt flag is clear
  logic irqCause;
  logic irqIssue;

  assign irqCause = (irqEn_reg[1] & (ostFlag_reg | ostEvent))
                  | (irqEn_reg[0] & (cbcFlag_reg | cbcEvent));
  assign irqIssue = irqCause & ~intFlag_reg;

  // a pending cause re-fires once the flag is cleared
  always_comb begin
    intFlag_next = intFlag_reg;
    if (irqIssue)
      intFlag_next = 1'b1;
    else if (clrInt)
      intFlag_next = 1'b0;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      intFlag_reg  <= 1'b0;
      faultIrqLine <= 1'b0;
    end else begin
      intFlag_reg  <= intFlag_next;
      faultIrqLine <= irqIssue;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky event status, write one to clear, masked onto a level irq
  logic [2:0] evtStat_reg;
  logic [2:0] evtSet;

  assign evtSet = {ostEvent & ~ostFlag_reg, cbcEvent & ~cbcFlag_reg,
                   irqIssue};

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      evtStat_reg <= RST_EVT;
      irq         <= 1'b0;
    end else begin
      evtStat_reg <= evtSet | (evtStat_reg & ~(evtW1c ? wrData[2:0] : 3'h0));
      irq         <= |(evtStat_reg & evtMask_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path; unmapped and write-only registers read zero
  always_comb begin
    rdMux = 16'h0000;
    case (regIdx)
      IDX_SRC_SEL:  rdMux = srcSel_reg;
      IDX_ACTION:   rdMux = {12'h000, action_reg};
      IDX_IRQ_EN:   rdMux = {13'h0000, irqEn_reg, 1'b0};
      IDX_STATUS:   rdMux = {13'h0000, ostFlag_reg, cbcFlag_reg, intFlag_reg};
      IDX_EVT_STAT: rdMux = {13'h0000, evtStat_reg};
      IDX_EVT_MASK: rdMux = {13'h0000, evtMask_reg};
      default:      rdMux = 16'h0000;
    endcase
  end

  // read data loaded as waitrequest falls, held until the next read
  always_ff @(posedge sys_clk) begin
    if (srst)
      avsReaddata <= 32'h0000_0000;
    else if (busState_reg == PTZ_BUS_IDLE && avsRead)
      avsReaddata <= {16'h0000, rdMux};
  end

  ////////////////////////////////////////////////////////////////////////////
  // output override; enable low gives the high-impedance action
  logic       tripActive;
  logic [1:0] actA;
  logic [1:0] actB;

  assign tripActive = ostFlag_reg | cbcOverride_reg;
  assign actA       = action_reg[ACT_A_LSB +: 2];
  assign actB       = action_reg[ACT_B_LSB +: 2];

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pwmOutFirst   <= 1'b0;
      pwmOutFirstOe <= 1'b0;
    end else begin
      pwmOutFirst   <= pwmInFirst;
      pwmOutFirstOe <= 1'b1;
      if (tripActive) begin
        case (actA)
          ACT_HIZ:  pwmOutFirstOe <= 1'b0;
          ACT_HIGH: pwmOutFirst   <= 1'b1;
          ACT_LOW:  pwmOutFirst   <= 1'b0;
          default:  pwmOutFirst   <= pwmInFirst;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pwmOutSecond   <= 1'b0;
      pwmOutSecondOe <= 1'b0;
    end else begin
      pwmOutSecond   <= pwmInSecond;
      pwmOutSecondOe <= 1'b1;
      if (tripActive) begin
        case (actB)
          ACT_HIZ:  pwmOutSecondOe <= 1'b0;
          ACT_HIGH: pwmOutSecond   <= 1'b1;
          ACT_LOW:  pwmOutSecond   <= 1'b0;
          default:  pwmOutSecond   <= pwmInSecond;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  a_first_hiz: assert property (
    tripActive && actA == ACT_HIZ |=> !pwmOutFirstOe)
    else $error("first output not released on hi-z trip");
  a_second_high: assert property (
    tripActive && actB == ACT_HIGH |=> pwmOutSecond && pwmOutSecondOe)
    else $error("second output not forced high");
  a_ost_irq: assert property (
    ostEvent && irqEn_reg[1] && !intFlag_reg |=> faultIrqLine)
    else $error("one-shot trip raised no interrupt");
  a_cbc_irq: assert property (
    cbcEvent && irqEn_reg[0] && !intFlag_reg |=> faultIrqLine)
    else $error("per-cycle trip raised no interrupt");
  a_no_irq_off: assert property (
    irqEn_reg == 2'h0 |=> !faultIrqLine)
    else $error("interrupt while both enables clear");
  a_ost_flag_set: assert property (
    ostEvent |=> ostFlag_reg)
    else $error("one-shot flag not set");
  a_cbc_reset: assert property (
    cbcPinLive && clrCbc |=> cbcFlag_reg)
    else $error("per-cycle flag lost under live trip");
  a_cbc_release: assert property (
    cbcOverride_reg && tbZero && !cbcEvent |=> !cbcOverride_reg)
    else $error("override not released at zero");
  a_cbc_hold: assert property (
    cbcOverride_reg && !tbZero |=> cbcOverride_reg)
    else $error("override released away from zero");
  a_int_block: assert property (
    intFlag_reg |=> !faultIrqLine)
    else $error("interrupt while flag set");
  a_int_refire: assert property (
    $fell(intFlag_reg) && ostFlag_reg && irqEn_reg[1] |=> faultIrqLine)
    else $error("no pulse after flag clear");
  a_irq_pulse: assert property (
    faultIrqLine |=> !faultIrqLine)
    else $error("interrupt longer than one cycle");
  a_flag_stable: assert property (
    !ostEvent && !clrOst |=> $stable(ostFlag_reg))
    else $error("one-shot flag changed without cause");
  a_clear_reads0: assert property (
    busState_reg == PTZ_BUS_IDLE && avsRead && regIdx == IDX_CLEAR
    |=> avsReaddata == 32'h0000_0000)
    else $error("clear register read nonzero");

  c_ost_trip:    cover property (ostEvent ##1 ostFlag_reg);
  c_cbc_release: cover property (cbcOverride_reg ##1 !cbcOverride_reg);
  c_irq_pulse:   cover property (faultIrqLine);
  c_hiz:         cover property (tripActive && !pwmOutSecondOe);

endmodule // ptz_trip_zone
`default_nettype wire

// File: testbench/ptz_fault_model.sv
`timescale 1ns/100ps
`default_nettype none
// far side: fault pins with pull-ups, time base, gate driver inputs
module ptz_fault_model #(
  parameter int NUM_FAULT = 8,
  parameter int PERIOD    = 40
) (
  input  wire logic                 sys_clk,
  input  wire logic                 srst,
  input  wire logic [NUM_FAULT-1:0] faultReq,
  input  wire logic                 pwmOutFirst,
  input  wire logic                 pwmOutFirstOe,
  input  wire logic                 pwmOutSecond,
  input  wire logic                 pwmOutSecondOe,
  output logic      [NUM_FAULT-1:0] faultInN,
  output logic      [15:0]          timebaseCount,
  output logic                      pinFirst,
  output logic                      pinSecond
);
  // open-drain fault sources; the pull-up wins when nobody pulls low
  assign faultInN = ~faultReq;
  // gate driver inputs have pull-downs, so a released pin reads low
  assign pinFirst  = pwmOutFirstOe ? pwmOutFirst : 1'b0;
  assign pinSecond = pwmOutSecondOe ? pwmOutSecond : 1'b0;
  // up-counting time base; zero once per period is the release point
  always_ff @(posedge sys_clk) begin
    if (srst || timebaseCount == 16'(PERIOD - 1)) begin
      timebaseCount <= 16'h0000;
    end else begin
      timebaseCount <= timebaseCount + 16'h0001;
    end
  end
endmodule // ptz_fault_model
`default_nettype wire

// File: testbench/testbench.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin \
  samples_checked++; \
  if ((g) !== (e)) begin \
    n_errors++; \
    $display("Error %s expected %h seen %h", nm, e, g); \
  end \
end
module testbench;
  import ptz_pkg::*;
  logic        sys_clk = 1'b0;
  logic        srst = 1'b1;
  logic [8:0]  avsAddress = 9'h000;
  logic        avsRead = 1'b0;
  logic        avsWrite = 1'b0;
  logic [31:0] avsWritedata = 32'h0;
  logic [31:0] avsReaddata;
  logic        avsWaitrequest;
  logic [7:0]  faultReq = 8'h00;
  logic [7:0]  faultInN;
  logic [15:0] timebaseCount;
  logic        pwmInFirst = 1'b0;
  logic        pwmInSecond = 1'b0;
  logic        pwmOutFirst, pwmOutFirstOe, pwmOutSecond, pwmOutSecondOe;
  logic        pinFirst, pinSecond, faultIrqLine, irq;
  int          n_errors = 0;
  int          samples_checked = 0;
  int          pulseCnt = 0;
  logic        prevIrq = 1'b0;
  int          cycles = 0;

  always #50 sys_clk = ~sys_clk;

  ptz_trip_zone #(.NUM_FAULT(8)) uut (.sys_clk(sys_clk), .srst(srst),
    .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
    .avsWritedata(avsWritedata), .avsByteenable(4'h3),
    .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest),
    .faultInN(faultInN), .timebaseCount(timebaseCount),
    .pwmInFirst(pwmInFirst), .pwmInSecond(pwmInSecond),
    .pwmOutFirst(pwmOutFirst), .pwmOutFirstOe(pwmOutFirstOe),
    .pwmOutSecond(pwmOutSecond), .pwmOutSecondOe(pwmOutSecondOe),
    .faultIrqLine(faultIrqLine), .irq(irq));
  ptz_fault_model #(.NUM_FAULT(8), .PERIOD(40)) farSide (.sys_clk(sys_clk),
    .srst(srst), .faultReq(faultReq), .pwmOutFirst(pwmOutFirst),
    .pwmOutFirstOe(pwmOutFirstOe), .pwmOutSecond(pwmOutSecond),
    .pwmOutSecondOe(pwmOutSecondOe), .faultInN(faultInN),
    .timebaseCount(timebaseCount), .pinFirst(pinFirst),
    .pinSecond(pinSecond));

  //////////////////////////////////////////////////////////////////////////
  // count interrupt pulses; every high sample must follow a low one
  always @(posedge sys_clk) begin
    if (faultIrqLine === 1'b1) begin
      pulseCnt++;
      `CHK("pulseWidth", 1'b0, prevIrq)
    end
    prevIrq <= faultIrqLine;
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // one bus access; holds the request until waitrequest is seen low
  task automatic bus(input logic isWr, input logic [6:0] idx,
                     input logic [15:0] d, output logic [15:0] q);
    int n;
    n = 0;
    @(posedge sys_clk);
    avsAddress <= {idx, 2'b00};
    avsWritedata <= {16'h0000, d};
    avsWrite <= isWr;
    avsRead <= ~isWr;
    // no own limit: only the bench timeout ends a hung access
    do begin
      @(posedge sys_clk);
      n++;
    end while (avsWaitrequest !== 1'b0);
    q = avsReaddata[15:0];
    // slave answers one cycle after taking the request
    `CHK("waitEdges", 2, n)
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
  endtask

  task automatic wr(input logic [6:0] idx, input logic [15:0] d);
    logic [15:0] q;
    bus(1'b1, idx, d, q);
  endtask

  task automatic rdc(input logic [6:0] idx, input logic [15:0] e,
                     input string nm);
    logic [15:0] q;
    bus(1'b0, idx, 16'h0000, q);
    `CHK(nm, e, q)
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // bounded wait for a time-base value
  task automatic waitCnt(input logic [15:0] v);
    int n;
    n = 0;
    while (timebaseCount !== v && n < 100) begin
      @(posedge sys_clk);
      n++;
    end
  endtask

  // pin seen by the gate driver: {enable, level}
  function automatic logic [1:0] expPin(input int code, input logic p);
    case (code)
      0: return 2'b00;
      1: return 2'b11;
      2: return 2'b10;
      default: return {1'b1, p};
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rdc(IDX_IRQ_EN, 16'h0000, "irqEnReset");
    rdc(IDX_STATUS, 16'h0000, "statusReset");
    rdc(7'h7f, 16'h0000, "unmapped");
    `CHK("oeReset", 2'b11, {pwmOutFirstOe, pwmOutSecondOe})
    $display("test reset done");
  endtask

  // every action code on both outputs, forced trips, interrupts disabled
  task automatic t_actions();
    for (int c = 0; c < 4; c++) begin
      for (int p = 0; p < 2; p++) begin
        int cb;
        cb = 3 - c;
        pwmInFirst <= 1'(p);
        pwmInSecond <= ~1'(p);
        wr(IDX_ACTION, {12'h000, 2'(3 - c), 2'(c)});
        wr(IDX_FORCE, 16'h0004);
        tick(3);
        `CHK("pinFirst", expPin(c, 1'(p)), {pwmOutFirstOe, pinFirst})
        `CHK("pinB", expPin(cb, ~1'(p)), {pwmOutSecondOe, pinSecond})
        wr(IDX_CLEAR, 16'h0004);
        tick(3);
        `CHK("passFirst", {1'b1, 1'(p)}, {pwmOutFirstOe, pinFirst})
      end
    end
    wr(IDX_FORCE, 16'h0002);
    rdc(IDX_STATUS, 16'h0002, "forcePerCycle");
    rdc(IDX_FORCE, 16'h0000, "forceReadsZero");
    wr(IDX_CLEAR, 16'h0002);
    `CHK("noIrqDisabled", 0, pulseCnt)
    $display("test actions done");
  endtask

  // one-shot pin trip, interrupt latch and re-issue, event interrupt
  task automatic t_oneshot();
    wr(IDX_SRC_SEL, 16'h0100);
    wr(IDX_IRQ_EN, 16'h0004);
    wr(IDX_EVT_MASK, 16'h0001);
    faultReq <= 8'h01;
    tick(8);
    `CHK("pulseOne", 1, pulseCnt)
    rdc(IDX_STATUS, 16'h0005, "oneShotSet");
    `CHK("irqLevel", 1'b1, irq)
    wr(IDX_STATUS, 16'h0000);
    wr(IDX_CLEAR, 16'h0000);
    rdc(IDX_STATUS, 16'h0005, "statusReadOnly");
    faultReq <= 8'h00;
    `CHK("blockedWhileSet", 1, pulseCnt)
    wr(IDX_CLEAR, 16'h0001);
    tick(4);
    `CHK("reissue", 2, pulseCnt)
    rdc(IDX_STATUS, 16'h0005, "latchHeld");
    wr(IDX_CLEAR, 16'h0007);
    tick(4);
    rdc(IDX_STATUS, 16'h0000, "allClear");
    rdc(IDX_CLEAR, 16'h0000, "clearReadsZero");
    `CHK("silent", 2, pulseCnt)
    rdc(IDX_EVT_STAT, 16'h0007, "evtStatus");
    wr(IDX_EVT_STAT, 16'h0007);
    tick(3);
    `CHK("irqCleared", 1'b0, irq)
    rdc(IDX_EVT_STAT, 16'h0000, "evtCleared");
    $display("test one-shot done");
  endtask

  // per-cycle pin trip, re-set on clear, release at counter zero only
  task automatic t_percycle();
    pwmInFirst <= 1'b0;
    pwmInSecond <= 1'b0;
    wr(IDX_ACTION, 16'h0005);
    wr(IDX_SRC_SEL, 16'h0002);
    wr(IDX_IRQ_EN, 16'h0002);
    faultReq <= 8'h02;
    tick(8);
    `CHK("pcPulse", 3, pulseCnt)
    rdc(IDX_STATUS, 16'h0003, "pcSet");
    wr(IDX_CLEAR, 16'h0002);
    tick(2);
    rdc(IDX_STATUS, 16'h0003, "pcReset");
    waitCnt(16'd12);
    faultReq <= 8'h00;
    tick(5);
    wr(IDX_CLEAR, 16'h0003);
    rdc(IDX_STATUS, 16'h0000, "pcCleared");
    waitCnt(16'd30);
    `CHK("heldToZero", 2'b11, {pinFirst, pinSecond})
    waitCnt(16'd0);
    tick(3);
    `CHK("released", 2'b00, {pinFirst, pinSecond})
    `CHK("pcPulses", 3, pulseCnt)
    $display("test per-cycle done");
  endtask

  initial begin
    repeat (12) @(posedge sys_clk);
    srst <= 1'b0;
    tick(2);
    t_reset();
    t_actions();
    t_oneshot();
    t_percycle();
    end_of_test();
  end
endmodule // testbench
`default_nettype wire
